// *** rtl/eeprom_host_pkg.sv ***
// Constants, command codes and frame helpers for the serial EEPROM host
package eeprom_host_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_NS = 50;
  localparam int SK_HALF_NS = 2000;
  localparam int SETUP_NS = 200;
  localparam int CS_LOW_NS = 1000;
  localparam int STATUS_NS = 1000;
  localparam int WRITE_MAX_NS = 15_000_000;
  // Least times round up, the longest one rounds down
  localparam int SK_HALF_CYC = (SK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int CS_LOW_CYC = (CS_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int STATUS_CYC = (STATUS_NS + CLK_NS - 1) / CLK_NS;
  localparam int WRITE_MAX_CYC = WRITE_MAX_NS / CLK_NS;

  // ==========================================================
  // Frame layout
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;
  localparam int GUARD_W = 6;
  localparam int HEAD_W = 9;
  localparam int FRAME_W = HEAD_W + DATA_W;
  localparam int CNT_W = 5;
  localparam logic START_BIT = 1'h1;
  localparam logic DUMMY_BIT = 1'h0;
  localparam logic READY_BIT = 1'h1;
  localparam logic [DATA_W-1:0] NO_DATA = 16'h0000;

  // ==========================================================
  // Opcodes and special addresses
  localparam logic [1:0] OPC_READ = 2'h2;
  localparam logic [1:0] OPC_WRITE = 2'h1;
  localparam logic [1:0] OPC_SPECIAL = 2'h0;
  localparam logic [1:0] OPC_CLEAR = 2'h3;
  localparam logic [ADDR_W-1:0] SPC_UNLOCK = 6'h30;
  localparam logic [ADDR_W-1:0] SPC_BULK = 6'h10;
  localparam logic [ADDR_W-1:0] SPC_LOCK = 6'h00;
  localparam logic [ADDR_W-1:0] SPC_CLEAR = 6'h3F;
  localparam logic [ADDR_W-1:0] SPC_FREEZE = 6'h00;

  typedef enum logic [3:0] {
    OP_READ,
    OP_WRITE,
    OP_BULK_WRITE,
    OP_WRITE_UNLOCK,
    OP_WRITE_LOCK,
    OP_GUARD_READ,
    OP_GUARD_UNLOCK,
    OP_GUARD_CLEAR,
    OP_GUARD_WRITE,
    OP_GUARD_FREEZE
  } host_op_e;

  // ==========================================================
  // Decoding
  function automatic logic [HEAD_W-2:0] instr_bits(
    input host_op_e op,
    input logic [ADDR_W-1:0] addr
  );
    case (op)
      OP_READ: instr_bits = {OPC_READ, addr};
      OP_WRITE: instr_bits = {OPC_WRITE, addr};
      OP_BULK_WRITE: instr_bits = {OPC_SPECIAL, SPC_BULK};
      OP_WRITE_UNLOCK: instr_bits = {OPC_SPECIAL, SPC_UNLOCK};
      OP_GUARD_READ: instr_bits = {OPC_READ, addr};
      OP_GUARD_UNLOCK: instr_bits = {OPC_SPECIAL, SPC_UNLOCK};
      OP_GUARD_CLEAR: instr_bits = {OPC_CLEAR, SPC_CLEAR};
      OP_GUARD_WRITE: instr_bits = {OPC_WRITE, addr};
      OP_GUARD_FREEZE: instr_bits = {OPC_SPECIAL, SPC_FREEZE};
      default: instr_bits = {OPC_SPECIAL, SPC_LOCK};
    endcase
  endfunction : instr_bits

  function automatic logic has_data(input host_op_e op);
    has_data = (op == OP_WRITE) || (op == OP_BULK_WRITE);
  endfunction : has_data

  function automatic logic is_guard(input host_op_e op);
    is_guard = (op == OP_GUARD_READ) || (op == OP_GUARD_UNLOCK) ||
      (op == OP_GUARD_CLEAR) || (op == OP_GUARD_WRITE) ||
      (op == OP_GUARD_FREEZE);
  endfunction : is_guard

  function automatic logic needs_armed(input host_op_e op);
    needs_armed = (op == OP_GUARD_CLEAR) || (op == OP_GUARD_WRITE) ||
      (op == OP_GUARD_FREEZE);
  endfunction : needs_armed

  function automatic logic needs_enable(input host_op_e op);
    needs_enable = has_data(op) || needs_armed(op) ||
      (op == OP_GUARD_UNLOCK);
  endfunction : needs_enable

  function automatic logic needs_allow(input host_op_e op);
    needs_allow = needs_enable(op) || (op == OP_WRITE_UNLOCK);
  endfunction : needs_allow

  function automatic logic is_program(input host_op_e op);
    is_program = has_data(op) || needs_armed(op);
  endfunction : is_program

  function automatic logic is_read(input host_op_e op);
    is_read = (op == OP_READ) || (op == OP_GUARD_READ);
  endfunction : is_read

endpackage : eeprom_host_pkg

// *** rtl/bit_sync.sv ***
// Two-stage synchroniser for one level from outside the clock domain
`timescale 1ns/1ps
module bit_sync (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic async_in,
  output logic sync_out
);

  // ==========================================================
  // Stages
  logic meta;

  // First stage feeds only the second
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule : bit_sync

// *** rtl/eeprom_host.sv ***
// Host controller driving a four-wire serial EEPROM with a guard register
//
// How it works
// [R1] Data changes on the clock fall so it is steady at each rising edge.
// [R2] A read returns a leading 0 dummy bit, then 16 data bits.
// [R3] The device updates its output on the rising clock edge.
// [R4] Continued clocking streams following words without further dummy bits.
// [R5] Programming is disabled at start; unlock must come before programming.
// [R6] Programming stays enabled until a lock instruction.
// [R7] After the last write bit, select drops before the next rising edge.
// [R8] Program-allow is high while loading writes, ignored afterwards.
// [R9] Busy shows as 0 on the output, ready as 1, after reselect.
// [R10] Select stays low for the minimum time between instructions.
// [R11] Bulk write only runs while the guard register is cleared.
// [R12] Bulk write stores one pattern everywhere, with the same busy report.
// [R13] Lock blocks programming; reads always work.
// [R14] Guard-select low means the instruction targets the memory array.
// [R15] Guard read: guard-select high, dummy 0 then the stored address.
// [R16] Guard unlock needs programming enabled and both qualifiers high.
// [R17] Guard clear, write, freeze need guard unlock immediately before.
// [R18] Guard clear removes protection; qualifiers high only while loading.
// [R19] Clear and write of all ones differ on last word and bulk write.
// [R20] Words at or above the stored guard address refuse writes.
// [R21] Guard write needs a guard clear first, with both qualifiers high.
// [R22] Frame: start bit 1, two opcode bits, six address bits.
// [R23] Opcode 00 selects unlock, bulk write or lock by top address bits.
// [R24] Guard clear is 11 with 111111; guard freeze is 00 with 000000.
// [R25] Guard freeze is final; the guard register never changes again.
// [R26] Refused programming starts no write cycle and changes nothing.
// [R27] The device output floats while deselected or idle; the model drives the inverse of its last bit.
`timescale 1ns/1ps
module eeprom_host
  import eeprom_host_pkg::*;
#(
  parameter int WRITE_TIMEOUT_CYC = WRITE_MAX_CYC,
  parameter int COUNT_W = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire host_op_e cmd_op,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [DATA_W-1:0] cmd_data,
  input wire logic [COUNT_W-1:0] cmd_count,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_data,
  output logic done,
  output logic error,
  output logic select_pin,
  output logic shift_clock_pin,
  output logic serial_input_pin,
  output logic program_allow_pin,
  output logic guard_select_pin,
  input wire logic serial_output_pin
);

  localparam int TMR_W = $clog2(WRITE_TIMEOUT_CYC + 1);

  typedef enum logic [2:0] {
    S_IDLE,
    S_SETUP,
    S_SHIFT,
    S_READ,
    S_DESEL,
    S_POLL,
    S_FINISH
  } state_e;

  // ==========================================================
  // State
  state_e state;
  host_op_e op;
  logic [FRAME_W-1:0] frame;
  logic [CNT_W-1:0] bits_left;
  logic [CNT_W-1:0] seen;
  logic [COUNT_W-1:0] words_left;
  logic [DATA_W-1:0] rd_sr;
  logic [TMR_W-1:0] tmr;
  logic first_bit;
  logic poll_pending;
  logic wr_en;
  logic guard_armed;
  logic guard_cleared;
  logic dev_out_sync;

  // Device output is a pin: two stages before anything reads it
  bit_sync u_out_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in(serial_output_pin),
    .sync_out(dev_out_sync)
  );

  // ==========================================================
  // Decoding
  wire logic fire = (state == S_IDLE) && cmd_valid;
  wire logic refuse = (needs_enable(cmd_op) && !wr_en) || // [R16]
    (needs_armed(cmd_op) && !guard_armed) ||
    (cmd_op == OP_GUARD_WRITE && !guard_cleared) ||
    (cmd_op == OP_BULK_WRITE && !guard_cleared);
  wire logic phase_end = (tmr == '0);
  wire logic last_bit = (bits_left == CNT_W'(1));
  wire logic [CNT_W-1:0] data_bits = is_guard(op) ? CNT_W'(GUARD_W) :
    CNT_W'(DATA_W);
  wire logic word_end = (seen == data_bits - CNT_W'(1));
  wire logic last_word = is_guard(op) || (words_left == COUNT_W'(1));
  wire logic [DATA_W-1:0] next_word = {rd_sr[DATA_W-2:0], dev_out_sync};
  wire logic status_valid =
    (tmr < TMR_W'(WRITE_TIMEOUT_CYC - STATUS_CYC));
  wire logic [FRAME_W-1:0] new_frame = // [R23] [R24]
    {START_BIT, instr_bits(cmd_op, cmd_addr), cmd_data};
  wire logic [CNT_W-1:0] new_bits = has_data(cmd_op) ? CNT_W'(FRAME_W) :
    CNT_W'(HEAD_W);
  wire logic [COUNT_W-1:0] new_words = (cmd_count == '0) ?
    COUNT_W'(1) : cmd_count;

  assign cmd_ready = (state == S_IDLE);

  // ==========================================================
  // Host-side view of the device's write and guard state
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_en <= 1'b0; // [R5]
      guard_armed <= 1'b0;
      guard_cleared <= 1'b0;
    end
    else if (fire && !refuse)
    begin
      if (cmd_op == OP_WRITE_UNLOCK)
        wr_en <= 1'b1; // [R6]
      else if (cmd_op == OP_WRITE_LOCK)
        wr_en <= 1'b0; // [R13]
      // Any other accepted instruction in between cancels the arming
      guard_armed <= (cmd_op == OP_GUARD_UNLOCK); // [R17]
      if (cmd_op == OP_GUARD_CLEAR)
        guard_cleared <= 1'b1; // [R21]
      else if (cmd_op == OP_GUARD_WRITE || cmd_op == OP_GUARD_FREEZE)
        guard_cleared <= 1'b0; // [R11]
    end
  end

  // ==========================================================
  // Frame sequencer; the serial clock is divided from core_clk
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= S_IDLE;
      op <= OP_WRITE_LOCK;
      frame <= '0;
      bits_left <= '0;
      seen <= '0;
      words_left <= '0;
      rd_sr <= '0;
      tmr <= '0;
      first_bit <= 1'b0;
      poll_pending <= 1'b0;
      select_pin <= 1'b0;
      shift_clock_pin <= 1'b0;
      serial_input_pin <= 1'b0;
      program_allow_pin <= 1'b0;
      guard_select_pin <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= '0;
      done <= 1'b0;
      error <= 1'b0;
    end
    else
    begin
      rsp_valid <= 1'b0;
      done <= (state == S_FINISH);
      if (!phase_end)
        tmr <= tmr - TMR_W'(1);
      case (state)
        S_IDLE:
        begin
          if (fire)
          begin
            op <= cmd_op;
            error <= refuse; // [R26]
            if (refuse)
              state <= S_FINISH; // [R5]
            else
            begin
              frame <= new_frame; // [R22]
              bits_left <= new_bits;
              words_left <= new_words;
              serial_input_pin <= START_BIT;
              program_allow_pin <= needs_allow(cmd_op); // [R8]
              guard_select_pin <= is_guard(cmd_op); // [R14]
              tmr <= TMR_W'(SETUP_CYC - 1);
              state <= S_SETUP;
            end
          end
        end
        S_SETUP:
        begin
          // Clock low and qualifiers settled before select rises
          if (phase_end)
          begin
            select_pin <= 1'b1; // [R1]
            tmr <= TMR_W'(SK_HALF_CYC - 1);
            state <= S_SHIFT;
          end
        end
        S_SHIFT:
        begin
          if (phase_end)
          begin
            tmr <= TMR_W'(SK_HALF_CYC - 1);
            shift_clock_pin <= !shift_clock_pin;
            if (shift_clock_pin && last_bit)
            begin
              program_allow_pin <= 1'b0; // [R8]
              guard_select_pin <= 1'b0; // [R18]
              serial_input_pin <= 1'b0;
              if (is_read(op))
              begin
                first_bit <= 1'b1;
                seen <= '0;
                rd_sr <= '0;
                state <= S_READ;
              end
              else
              begin
                // Falling select ends the frame before another rise
                select_pin <= 1'b0; // [R7]
                poll_pending <= is_program(op); // [R12]
                tmr <= TMR_W'(CS_LOW_CYC - 1);
                state <= S_DESEL;
              end
            end
            else if (shift_clock_pin)
            begin
              // New bit on the fall, so it is stable at the next rise
              frame <= frame << 1; // [R1]
              serial_input_pin <= frame[FRAME_W-2];
              bits_left <= bits_left - CNT_W'(1);
            end
          end
        end
        S_READ:
        begin
          if (phase_end)
          begin
            tmr <= TMR_W'(SK_HALF_CYC - 1);
            shift_clock_pin <= !shift_clock_pin;
            // Sample late in the low phase: the device moved at the rise
            if (!shift_clock_pin && first_bit)
            begin
              first_bit <= 1'b0;
              if (dev_out_sync != DUMMY_BIT)
                error <= 1'b1; // [R2]
            end
            else if (!shift_clock_pin)
            begin
              rd_sr <= next_word; // [R3]
              seen <= seen + CNT_W'(1);
              if (word_end)
              begin
                rsp_valid <= 1'b1;
                rsp_data <= next_word; // [R15]
                seen <= '0;
                rd_sr <= '0;
                words_left <= words_left - COUNT_W'(1); // [R4]
                if (last_word)
                begin
                  shift_clock_pin <= 1'b0;
                  select_pin <= 1'b0;
                  poll_pending <= 1'b0;
                  tmr <= TMR_W'(CS_LOW_CYC - 1);
                  state <= S_DESEL;
                end
              end
            end
          end
        end
        S_DESEL:
        begin
          if (phase_end && poll_pending)
          begin
            select_pin <= 1'b1; // [R9]
            tmr <= TMR_W'(WRITE_TIMEOUT_CYC - 1);
            state <= S_POLL;
          end
          else if (phase_end)
            state <= S_FINISH; // [R10]
        end
        S_POLL:
        begin
          // Timeout bounds the wait if ready never appears
          if ((status_valid && dev_out_sync == READY_BIT) || phase_end)
          begin
            error <= error || (dev_out_sync != READY_BIT);
            select_pin <= 1'b0; // [R9]
            poll_pending <= 1'b0;
            tmr <= TMR_W'(CS_LOW_CYC - 1);
            state <= S_DESEL;
          end
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Checks
  logic [CNT_W-1:0] low_cnt;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      low_cnt <= CNT_W'(CS_LOW_CYC);
    else if (select_pin)
      low_cnt <= '0;
    else if (low_cnt < CNT_W'(CS_LOW_CYC))
      low_cnt <= low_cnt + CNT_W'(1);
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_last_write_fall;
    state == S_SHIFT && phase_end && shift_clock_pin && last_bit &&
      has_data(op);
  endsequence
  sequence s_parked_low;
    (!select_pin && !shift_clock_pin) [*8];
  endsequence
  sequence s_refused_entry;
    fire && refuse;
  endsequence
  sequence s_refused_done;
    state == S_FINISH ##1 (done && error && !select_pin);
  endsequence

  property p_clk_low_at_select;
    $rose(select_pin) |-> !shift_clock_pin;
  endproperty
  a_clk_low_at_select: assert property (p_clk_low_at_select) // [R1]
    else $error("serial clock high when select rose");

  property p_data_steady_at_rise;
    $rose(shift_clock_pin) |-> $stable(serial_input_pin);
  endproperty
  a_data_steady_at_rise: assert property (p_data_steady_at_rise) // [R1]
    else $error("serial data changed on a rising clock");

  property p_clk_high_time;
    $rose(shift_clock_pin) |-> shift_clock_pin [*8];
  endproperty
  a_clk_high_time: assert property (p_clk_high_time) // [R1]
    else $error("serial clock high phase too short");

  property p_start_bit;
    state == S_SETUP && phase_end |=> serial_input_pin == START_BIT;
  endproperty
  a_start_bit: assert property (p_start_bit) // [R22]
    else $error("frame did not open with the start bit");

  property p_write_ends_frame;
    s_last_write_fall |=> s_parked_low;
  endproperty
  a_write_ends_frame: assert property (p_write_ends_frame) // [R7]
    else $error("select not dropped after last write bit");

  property p_allow_while_loading;
    state == S_SHIFT && has_data(op) |-> program_allow_pin;
  endproperty
  a_allow_while_loading: assert property (p_allow_while_loading) // [R8]
    else $error("program-allow low while loading a write");

  property p_qualifiers_released;
    state == S_READ || state == S_POLL |->
      !program_allow_pin && !guard_select_pin;
  endproperty
  a_qualifiers_released: assert property (p_qualifiers_released) // [R18]
    else $error("qualifier still high after loading");

  property p_guard_select_match;
    state == S_SHIFT |-> guard_select_pin == is_guard(op);
  endproperty
  a_guard_select_match: assert property (p_guard_select_match) // [R14]
    else $error("guard-select does not match the command");

  property p_deselect_time;
    // Count already holds the last low cycle when the rise is seen
    $rose(select_pin) |-> low_cnt >= CNT_W'(CS_LOW_CYC);
  endproperty
  a_deselect_time: assert property (p_deselect_time) // [R10]
    else $error("select low time too short");

  property p_refused_no_frame;
    s_refused_entry |=> s_refused_done;
  endproperty
  a_refused_no_frame: assert property (p_refused_no_frame) // [R5]
    else $error("refused command reached the pins");

  property p_ready_ends_poll;
    state == S_POLL && status_valid && dev_out_sync == READY_BIT |=>
      !select_pin ##1 state == S_DESEL;
  endproperty
  a_ready_ends_poll: assert property (p_ready_ends_poll) // [R9]
    else $error("ready status did not end the poll");

endmodule : eeprom_host

// *** tb/eeprom_dev_model.sv ***
// Behavioural serial EEPROM with guard register, far side of the host
`timescale 1ns/1ps
module eeprom_dev_model #(
  parameter int WRITE_NS = 20000
) (
  input wire logic select_pin,
  input wire logic shift_clock_pin,
  input wire logic serial_input_pin,
  input wire logic program_allow_pin,
  input wire logic guard_select_pin,
  output logic serial_output_pin
);
  // ==========================================================
  // State
  logic [15:0] mem [16];
  logic [15:0] osr;
  logic [23:0] sr;
  logic [5:0] gaddr = 6'h3F;
  logic [5:0] ad;
  logic [1:0] op;
  logic [3:0] rptr;
  logic wen = 0, armed = 0, cleared = 1, frozen = 0, busy = 0, was;
  logic status = 0, started = 0, rd = 0, dval = 0;
  int cnt = 0, ocnt = 0, pend = 0;
  initial for (int i = 0; i < 16; i++) mem[i] = 16'h5A00 + 16'(i);
  // Released line shows the inverse of the last bit, never a stale copy
  assign serial_output_pin = !select_pin ? ~dval :
    (status && !started) ? ~busy : rd ? dval : ~dval;

  // ==========================================================
  // Decode after start bit, opcode and address
  task automatic decode();
    op = sr[7:6];
    ad = sr[5:0];
    was = armed;
    armed = 0;
    if (guard_select_pin && op == 2'h2)
    begin
      rd = 1;
      osr = {gaddr, 10'h000};
    end
    else if (guard_select_pin && program_allow_pin && op == 2'h0 &&
      ad[5:4] == 2'h3)
      armed = wen;
    else if (guard_select_pin && program_allow_pin && was && !frozen)
      pend = (op == 2'h3 && ad == 6'h3F) ? 3 : (op == 2'h1 && cleared) ?
        4 : (op == 2'h0 && ad == 6'h00) ? 5 : 0;
    else if (guard_select_pin)
      pend = 0;
    else if (op == 2'h2)
    begin
      rd = 1;
      rptr = ad[3:0];
      osr = mem[rptr];
    end
    else if (op == 2'h0 && ad[5:4] == 2'h3)
      wen = wen || program_allow_pin;
    else if (op == 2'h0 && ad[5:4] == 2'h0)
      wen = 0;
    else if (wen && program_allow_pin)
      pend = (op == 2'h0 && ad[5:4] == 2'h1 && cleared) ? 2 :
        (op == 2'h1 && (cleared || ad[3:0] < gaddr[3:0])) ? 1 : 0;
    dval = 0;
  endtask : decode

  // ==========================================================
  // Sampled and driven on the clock rise only
  always @(posedge shift_clock_pin)
  begin
    if (select_pin && rd)
    begin
      dval = osr[15];
      osr = osr << 1;
      ocnt++;
      if (ocnt == 16)
      begin
        rptr++;
        osr = mem[rptr];
        ocnt = 0;
      end
    end
    else if (select_pin && !started)
    begin
      started = serial_input_pin;
      if (started)
        status = 0;
      cnt = 0;
    end
    else if (select_pin)
    begin
      sr = {sr[22:0], serial_input_pin};
      cnt++;
      if (cnt == 8)
        decode();
    end
  end

  // ==========================================================
  // Select fall starts the timed cycle and clears the frame state
  always @(negedge select_pin)
  begin
    if (started && !rd)
    begin
      status = 1;
      if ((pend < 3 && cnt == 24) || (pend > 2 && cnt == 8))
      begin
        case (pend)
          1: mem[ad[3:0]] = sr[15:0];
          2: for (int i = 0; i < 16; i++) mem[i] = sr[15:0];
          3: begin gaddr = 6'h3F; cleared = 1; end
          4: begin gaddr = ad; cleared = 0; end
          5: frozen = 1;
          default: ;
        endcase
        busy = pend != 0;
        busy <= #(WRITE_NS) 1'b0;
      end
    end
    started = 0;
    rd = 0;
    pend = 0;
    cnt = 0;
    ocnt = 0;
  end
endmodule : eeprom_dev_model

// *** tb/eeprom_host_tb.sv ***
// Self-checking bench for the serial EEPROM host against a device model
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  samples_checked++; \
  if ((got) !== (exp)) \
  begin \
    errors++; \
    $display("MISMATCH %s exp=%0h got=%0h", nm, exp, got); \
  end
module eeprom_host_tb
  import eeprom_host_pkg::*;
;
  // ==========================================================
  // Signals
  logic core_clk = 0, rst_n = 0, cmd_valid = 0;
  host_op_e cmd_op = OP_READ;
  logic [ADDR_W-1:0] cmd_addr = 6'h00;
  logic [DATA_W-1:0] cmd_data = 16'h0000;
  logic [7:0] cmd_count = 8'h00;
  logic cmd_ready, rsp_valid, done, error, select_pin, shift_clock_pin;
  logic serial_input_pin, program_allow_pin, guard_select_pin;
  logic serial_output_pin, err_seen, pin_act;
  logic [DATA_W-1:0] rsp_data, d;
  logic [15:0] sm [16];
  logic [15:0] rq [$];
  logic [5:0] a;
  int errors = 0, samples_checked = 0;
  integer seed = 32'hCF07E63F;
  always #25 core_clk = ~core_clk;

  eeprom_host #(.WRITE_TIMEOUT_CYC(2000)) eeprom_host_i (
    .core_clk(core_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .cmd_count(cmd_count), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .done(done), .error(error),
    .select_pin(select_pin), .shift_clock_pin(shift_clock_pin),
    .serial_input_pin(serial_input_pin),
    .program_allow_pin(program_allow_pin),
    .guard_select_pin(guard_select_pin),
    .serial_output_pin(serial_output_pin));

  eeprom_dev_model eeprom_dev_model_i (
    .select_pin(select_pin), .shift_clock_pin(shift_clock_pin),
    .serial_input_pin(serial_input_pin),
    .program_allow_pin(program_allow_pin),
    .guard_select_pin(guard_select_pin),
    .serial_output_pin(serial_output_pin));

  // Registered outputs are sampled mid-cycle, clear of the launching edge
  always @(negedge core_clk)
  begin
    if (rsp_valid === 1'b1)
      rq.push_back(rsp_data);
    if (select_pin === 1'b1)
      pin_act = 1'b1;
  end

  // ==========================================================
  // Tasks
  // Sequential read wraps round the sixteen words
  function automatic logic [15:0] exp_word(input logic [5:0] ad,
    input int k);
    exp_word = sm[(int'(ad[3:0]) + k) % 16];
  endfunction : exp_word

  task automatic report_and_stop();
    if (errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  task automatic run(input host_op_e op, input logic [5:0] ad,
    input logic [15:0] dt, input logic [7:0] n);
    int k;
    rq.delete();
    pin_act = 1'b0;
    @(posedge core_clk);
    cmd_op <= op;
    cmd_addr <= ad;
    cmd_data <= dt;
    cmd_count <= n;
    cmd_valid <= 1'b1;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    k = 0;
    do
    begin
      @(negedge core_clk);
      k++;
    end
    while (done !== 1'b1 && k < 25000);
    `CHK("done", 1'b1, done)
    `CHK("ready", 1'b1, cmd_ready)
    err_seen = error;
  endtask : run

  task automatic rd_chk(input logic [5:0] ad, input int n);
    run(OP_READ, ad, 16'h0000, 8'(n));
    `CHK("read_err", 1'b0, err_seen)
    for (int k = 0; k < n; k++)
    begin
      `CHK("read_word", exp_word(ad, k), rq[k])
    end
  endtask : rd_chk

  // ==========================================================
  // Scenarios
  initial
  begin
    for (int i = 0; i < 16; i++) sm[i] = 16'h5A00 + 16'(i);
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    rd_chk(6'h05, 1);
    run(OP_WRITE, 6'h02, 16'h1234, 8'h00);
    `CHK("refused", 1'b1, err_seen)
    `CHK("pins_idle", 1'b0, pin_act)
    run(OP_WRITE_UNLOCK, 6'h00, 16'h0000, 8'h00);
    repeat (3)
    begin
      a = 6'($random(seed));
      d = 16'($random(seed));
      run(OP_WRITE, a, d, 8'h00);
      sm[a[3:0]] = d;
      `CHK("write_err", 1'b0, err_seen)
    end
    // Upper address bits must be ignored, and the stream wraps
    rd_chk(6'h3E, 3);
    run(OP_GUARD_CLEAR, 6'h00, 16'h0000, 8'h00);
    `CHK("unarmed", 1'b1, err_seen)
    run(OP_GUARD_UNLOCK, 6'h00, 16'h0000, 8'h00);
    run(OP_GUARD_CLEAR, 6'h00, 16'h0000, 8'h00);
    `CHK("clear_err", 1'b0, err_seen)
    d = 16'($random(seed));
    run(OP_BULK_WRITE, 6'h00, d, 8'h00);
    for (int i = 0; i < 16; i++) sm[i] = d;
    run(OP_GUARD_UNLOCK, 6'h00, 16'h0000, 8'h00);
    run(OP_GUARD_WRITE, 6'h08, 16'h0000, 8'h00);
    run(OP_GUARD_READ, 6'h00, 16'h0000, 8'h01);
    `CHK("guard_addr", 16'h0008, rq[0])
    run(OP_WRITE, 6'h09, ~d, 8'h00);
    run(OP_WRITE, 6'h07, 16'hC3A5, 8'h00);
    sm[7] = 16'hC3A5;
    run(OP_BULK_WRITE, 6'h00, 16'h0F0F, 8'h00);
    `CHK("bulk_refused", 1'b1, err_seen)
    run(OP_WRITE_LOCK, 6'h00, 16'h0000, 8'h00);
    run(OP_WRITE, 6'h03, 16'hFFFF, 8'h00);
    `CHK("locked", 1'b1, err_seen)
    run(OP_GUARD_UNLOCK, 6'h00, 16'h0000, 8'h00);
    `CHK("unlock_refused", 1'b1, err_seen)
    run(OP_WRITE_UNLOCK, 6'h00, 16'h0000, 8'h00);
    run(OP_GUARD_UNLOCK, 6'h00, 16'h0000, 8'h00);
    run(OP_GUARD_FREEZE, 6'h00, 16'h0000, 8'h00);
    run(OP_GUARD_UNLOCK, 6'h00, 16'h0000, 8'h00);
    run(OP_GUARD_CLEAR, 6'h00, 16'h0000, 8'h00);
    run(OP_WRITE, 6'h0A, 16'h0000, 8'h00);
    rd_chk(6'h04, 8);
    run(OP_GUARD_READ, 6'h00, 16'h0000, 8'h01);
    `CHK("frozen_addr", 16'h0008, rq[0])
    report_and_stop();
  end

  // Bound set well above the longest expected sequence
  initial
  begin
    repeat (90000) @(posedge core_clk);
    errors++;
    report_and_stop();
  end
endmodule : eeprom_host_tb
